/* File: rtl/bcd_calendar_alarm_sqw.sv */
// calendar, alarm and square-wave core with its two-wire slave port
// assumes scl, sda and crystal arrive asynchronously; pads resolve oe
module bcd_calendar_alarm_sqw (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic crystal_in,
    output logic      square_wave_output,
    output logic      square_wave_oe,
    output logic      alarm_int_out,
    output logic      alarm_int_oe
);

    typedef struct packed {
        logic [1:0]          scl_sync;
        logic                scl_prev;
        logic [1:0]          sda_sync;
        logic                sda_prev;
        logic [1:0]          xtal_sync;
        logic                xtal_prev;
        logic [14:0]         div;
        logic [11:0]         stop_cnt;
        rtc_pkg::bus_state_t bus;
        logic [3:0]          bit_cnt;
        logic [7:0]          shift;
        logic [1:0]          phase;
        logic                rd_mode;
        logic [7:0]          ptr;
        logic                sda_drive;
        logic                alm_flag;
        logic                irq_en;
        logic                stop_flag;
        logic [7:0]          sec;
        logic [7:0]          min;
        logic [7:0]          hour;
        logic [7:0]          date;
        logic [7:0]          wday;
        logic [7:0]          mon;
        logic [7:0]          year;
        logic [7:0]          alm_min;
        logic [7:0]          alm_hour;
        logic [7:0]          alm_date;
        logic [7:0]          alm_wday;
        logic                sq_en;
        logic [1:0]          rs;
        logic                match_prev;
        logic                sq_level;
        logic                int_drive;
        logic                tie_low;
    } core_t;

    core_t s_q;
    core_t s_d;

    logic scl_s;
    logic sda_s;
    logic xtal_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic xtal_rise;
    logic sec_tick;
    logic osc_stopped;
    logic alarm_hit;
    logic wr_en;
    logic [7:0] wr_data;

    // BCD plus one, units 9 carry into tens
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // two-digit BCD year divisible by four
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4)
                   || (y[3:0] == 4'h8);
        end
    endfunction

    // last date of a month in BCD
    function automatic logic [7:0] month_end(input logic [7:0] m,
                                             input logic [7:0] y);
        unique case (m)
            8'h02: month_end = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    // register read mux, unmapped and unused bits read zero
    function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                          input core_t c);
        rd_reg = 8'h00;
        unique case (a)
            rtc_pkg::ADDR_CTL2: begin
                rd_reg[rtc_pkg::FLAG_BIT]  = c.alm_flag;
                rd_reg[rtc_pkg::IRQEN_BIT] = c.irq_en;
            end
            rtc_pkg::ADDR_SEC:      rd_reg = {c.stop_flag, c.sec[6:0]};
            rtc_pkg::ADDR_MIN:      rd_reg = c.min;
            rtc_pkg::ADDR_HOUR:     rd_reg = c.hour;
            rtc_pkg::ADDR_DATE:     rd_reg = c.date;
            rtc_pkg::ADDR_WDAY:     rd_reg = c.wday;
            rtc_pkg::ADDR_MON:      rd_reg = c.mon;
            rtc_pkg::ADDR_YEAR:     rd_reg = c.year;
            rtc_pkg::ADDR_ALM_MIN:  rd_reg = c.alm_min;
            rtc_pkg::ADDR_ALM_HOUR: rd_reg = c.alm_hour;
            rtc_pkg::ADDR_ALM_DATE: rd_reg = c.alm_date;
            rtc_pkg::ADDR_ALM_WDAY: rd_reg = c.alm_wday;
            rtc_pkg::ADDR_SQCTL: begin
                rd_reg[rtc_pkg::SQEN_BIT] = c.sq_en;
                rd_reg[1:0]               = c.rs;
            end
            default: rd_reg = 8'h00;
        endcase
    endfunction

    // synchronised pins and their edges
    assign scl_s     = s_q.scl_sync[1];
    assign sda_s     = s_q.sda_sync[1];
    assign xtal_s    = s_q.xtal_sync[1];
    assign scl_rise  = scl_s & ~s_q.scl_prev;
    assign scl_fall  = ~scl_s & s_q.scl_prev;
    assign bus_start = scl_s & s_q.sda_prev & ~sda_s;
    assign bus_stop  = scl_s & ~s_q.sda_prev & sda_s;
    assign xtal_rise = xtal_s & ~s_q.xtal_prev;
    assign sec_tick  = xtal_rise & (s_q.div == rtc_pkg::DIV_LAST);
    assign osc_stopped = (s_q.stop_cnt == rtc_pkg::OSC_STOP_CYC);

    // alarm compare over participating fields only
    assign alarm_hit =
        ~(&{s_q.alm_min[rtc_pkg::OFF_BIT], s_q.alm_hour[rtc_pkg::OFF_BIT],
            s_q.alm_date[rtc_pkg::OFF_BIT], s_q.alm_wday[rtc_pkg::OFF_BIT]})
        & (s_q.alm_min[rtc_pkg::OFF_BIT]
           | (s_q.alm_min[6:0] == s_q.min[6:0]))
        & (s_q.alm_hour[rtc_pkg::OFF_BIT]
           | (s_q.alm_hour[5:0] == s_q.hour[5:0]))
        & (s_q.alm_date[rtc_pkg::OFF_BIT]
           | (s_q.alm_date[5:0] == s_q.date[5:0]))
        & (s_q.alm_wday[rtc_pkg::OFF_BIT]
           | (s_q.alm_wday[2:0] == s_q.wday[2:0]));

    // next state of the whole core
    always_comb begin
        s_d     = s_q;
        wr_en   = 1'b0;
        wr_data = s_q.shift;

        // two-flop synchronisers, then previous values for edges
        s_d.scl_sync  = {s_q.scl_sync[0], scl_in};
        s_d.sda_sync  = {s_q.sda_sync[0], sda_in};
        s_d.xtal_sync = {s_q.xtal_sync[0], crystal_in};
        s_d.scl_prev  = scl_s;
        s_d.sda_prev  = sda_s;
        s_d.xtal_prev = xtal_s;

        // crystal divider and stop watchdog
        if (xtal_rise) begin
            s_d.div = s_q.div + 15'h0001;
        end
        if (xtal_s != s_q.xtal_prev) begin
            s_d.stop_cnt = 12'h000;
        end else if (!osc_stopped) begin
            s_d.stop_cnt = s_q.stop_cnt + 12'h001;
        end

        // time and calendar cascade on the seconds tick
        if (sec_tick) begin
            if (s_q.sec[6:0] == rtc_pkg::SEC_LAST[6:0]) begin
                s_d.sec = 8'h00;
                if (s_q.min == rtc_pkg::SEC_LAST) begin
                    s_d.min = 8'h00;
                    if (s_q.hour == rtc_pkg::HOUR_LAST) begin
                        s_d.hour = 8'h00;
                        s_d.wday = (s_q.wday == rtc_pkg::WDAY_LAST)
                                 ? 8'h00 : bcd_inc(s_q.wday);
                        if (s_q.date == month_end(s_q.mon, s_q.year)) begin
                            s_d.date = rtc_pkg::DAY_FIRST;
                            if (s_q.mon == rtc_pkg::MON_LAST) begin
                                s_d.mon = rtc_pkg::DAY_FIRST;
                                s_d.year = (s_q.year == rtc_pkg::YEAR_LAST)
                                         ? 8'h00 : bcd_inc(s_q.year);
                            end else begin
                                s_d.mon = bcd_inc(s_q.mon);
                            end
                        end else begin
                            s_d.date = bcd_inc(s_q.date);
                        end
                    end else begin
                        s_d.hour = bcd_inc(s_q.hour);
                    end
                end else begin
                    s_d.min = bcd_inc(s_q.min);
                end
            end else begin
                s_d.sec = bcd_inc(s_q.sec);
            end
        end

        // two-wire slave: start wins from any state, stop releases
        if (bus_start) begin
            s_d.bus       = rtc_pkg::BUS_RX;
            s_d.bit_cnt   = 4'h0;
            s_d.phase     = 2'h0;
            s_d.sda_drive = 1'b0;
        end else if (bus_stop) begin
            s_d.bus       = rtc_pkg::BUS_IDLE;
            s_d.sda_drive = 1'b0;
        end else begin
            unique case (s_q.bus)
                rtc_pkg::BUS_IDLE: s_d.sda_drive = 1'b0;
                rtc_pkg::BUS_RX: begin
                    if (scl_rise && s_q.bit_cnt != 4'h8) begin
                        s_d.shift   = {s_q.shift[6:0], sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall && s_q.bit_cnt == 4'h8) begin
                        s_d.bit_cnt   = 4'h0;
                        s_d.bus       = rtc_pkg::BUS_ACK;
                        s_d.sda_drive = 1'b1;
                        unique case (s_q.phase)
                            2'h0: begin
                                if (s_q.shift[7:1] == rtc_pkg::SLAVE_ADDR)
                                begin
                                    s_d.rd_mode = s_q.shift[0];
                                    s_d.phase   = 2'h1;
                                end else begin
                                    s_d.bus       = rtc_pkg::BUS_IDLE;
                                    s_d.sda_drive = 1'b0;
                                end
                            end
                            2'h1: begin
                                if (s_q.shift <= rtc_pkg::ADDR_LAST) begin
                                    s_d.ptr   = s_q.shift;
                                    s_d.phase = 2'h2;
                                end else begin
                                    s_d.bus       = rtc_pkg::BUS_IDLE;
                                    s_d.sda_drive = 1'b0;
                                end
                            end
                            default: begin
                                if (s_q.ptr <= rtc_pkg::ADDR_LAST) begin
                                    wr_en   = 1'b1;
                                    s_d.ptr = s_q.ptr + 8'h01;
                                end else begin
                                    s_d.bus       = rtc_pkg::BUS_IDLE;
                                    s_d.sda_drive = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                rtc_pkg::BUS_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_drive = 1'b0;
                        if (s_q.rd_mode) begin
                            s_d.bus       = rtc_pkg::BUS_TX;
                            s_d.shift     = rd_reg(s_q.ptr, s_q);
                            s_d.sda_drive = ~s_d.shift[7];
                            s_d.ptr       = s_q.ptr + 8'h01;
                            s_d.bit_cnt   = 4'h1;
                        end else begin
                            s_d.bus = rtc_pkg::BUS_RX;
                        end
                    end
                end
                rtc_pkg::BUS_TX: begin
                    if (scl_fall) begin
                        if (s_q.bit_cnt == 4'h8) begin
                            s_d.sda_drive = 1'b0;
                            s_d.bus       = rtc_pkg::BUS_TXACK;
                        end else begin
                            s_d.shift     = {s_q.shift[6:0], 1'b0};
                            s_d.sda_drive = ~s_q.shift[6];
                            s_d.bit_cnt   = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                rtc_pkg::BUS_TXACK: begin
                    if (scl_rise) begin
                        s_d.bus = sda_s ? rtc_pkg::BUS_IDLE
                                        : rtc_pkg::BUS_ACK;
                    end
                end
                default: begin
                    s_d.bus       = rtc_pkg::BUS_IDLE;
                    s_d.sda_drive = 1'b0;
                end
            endcase
        end

        // host register writes override the cascade
        if (wr_en) begin
            unique case (s_q.ptr)
                rtc_pkg::ADDR_CTL2: s_d.irq_en = wr_data[rtc_pkg::IRQEN_BIT];
                rtc_pkg::ADDR_SEC:  s_d.sec = wr_data & rtc_pkg::MASK_SEC;
                rtc_pkg::ADDR_MIN:  s_d.min = wr_data & rtc_pkg::MASK_MIN;
                rtc_pkg::ADDR_HOUR: s_d.hour = wr_data & rtc_pkg::MASK_HOUR;
                rtc_pkg::ADDR_DATE: s_d.date = wr_data & rtc_pkg::MASK_DATE;
                rtc_pkg::ADDR_WDAY: s_d.wday = wr_data & rtc_pkg::MASK_WDAY;
                rtc_pkg::ADDR_MON:  s_d.mon = wr_data & rtc_pkg::MASK_MON;
                rtc_pkg::ADDR_YEAR: s_d.year = wr_data;
                rtc_pkg::ADDR_ALM_MIN:  s_d.alm_min = wr_data;
                rtc_pkg::ADDR_ALM_HOUR:
                    s_d.alm_hour = wr_data & rtc_pkg::MASK_AHR;
                rtc_pkg::ADDR_ALM_DATE:
                    s_d.alm_date = wr_data & rtc_pkg::MASK_ADT;
                rtc_pkg::ADDR_ALM_WDAY:
                    s_d.alm_wday = wr_data & rtc_pkg::MASK_AWD;
                rtc_pkg::ADDR_SQCTL: begin
                    s_d.sq_en = wr_data[rtc_pkg::SQEN_BIT];
                    s_d.rs   = wr_data[1:0];
                end
                default: s_d.tie_low = 1'b0;
            endcase
        end

        // flags: hardware set wins over a host clear
        s_d.match_prev = alarm_hit;
        s_d.alm_flag = (alarm_hit & ~s_q.match_prev)
               | (s_q.alm_flag & ~(wr_en && s_q.ptr == rtc_pkg::ADDR_CTL2
                             && !wr_data[rtc_pkg::FLAG_BIT]));
        s_d.stop_flag = osc_stopped
                | (s_q.stop_flag & ~(wr_en && s_q.ptr == rtc_pkg::ADDR_SEC
                               && !wr_data[rtc_pkg::STOP_BIT]));
        s_d.int_drive = s_d.alm_flag & s_d.irq_en;

        // square-wave source by frequency select
        unique case (s_d.rs)
            rtc_pkg::FSEL_32K: s_d.sq_level = xtal_s;
            rtc_pkg::FSEL_1K:  s_d.sq_level = s_q.div[rtc_pkg::TAP_1K];
            rtc_pkg::FSEL_32:  s_d.sq_level = s_q.div[rtc_pkg::TAP_32];
            rtc_pkg::FSEL_1:   s_d.sq_level = s_q.div[rtc_pkg::TAP_1];
        endcase

        // synchronous reset of all control state
        if (sys_rst) begin
            s_d          = '0;
            s_d.bus      = rtc_pkg::BUS_IDLE;
            s_d.stop_flag = rtc_pkg::RST_STOP;
            s_d.sq_en    = rtc_pkg::RST_SQEN;
            s_d.rs       = rtc_pkg::RST_RS;
            s_d.irq_en   = rtc_pkg::RST_IRQEN;
            s_d.alm_flag = rtc_pkg::RST_FLAG;
            s_d.date     = rtc_pkg::RST_DATE;
            s_d.mon      = rtc_pkg::RST_MON;
            s_d.alm_hour = rtc_pkg::MASK_AHR & 8'h80;
            s_d.alm_date = rtc_pkg::MASK_ADT & 8'h80;
            s_d.alm_wday = rtc_pkg::MASK_AWD & 8'h80;
            s_d.alm_min  = 8'h80;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        s_q <= s_d;
    end

    // pins straight from flops; pads pull released lines high
    assign sda_out            = s_q.tie_low;
    assign sda_oe             = s_q.sda_drive;
    assign square_wave_output = s_q.sq_level;
    assign square_wave_oe     = s_q.sq_en;
    assign alarm_int_out      = s_q.tie_low;
    assign alarm_int_oe       = s_q.int_drive;

endmodule

/* File: rtl/rtc_pkg.sv */
// constants, register map and state codes of the calendar core
// assumes a 40 MHz ref_clk and a 32.768 kHz crystal sampled by it
package rtc_pkg;

    // fixed seven-bit bus address of the device
    localparam logic [6:0] SLAVE_ADDR = 7'h51;

    // register offsets
    localparam logic [7:0] ADDR_CTL1      = 8'h00;
    localparam logic [7:0] ADDR_CTL2      = 8'h01;
    localparam logic [7:0] ADDR_SEC       = 8'h02;
    localparam logic [7:0] ADDR_MIN       = 8'h03;
    localparam logic [7:0] ADDR_HOUR      = 8'h04;
    localparam logic [7:0] ADDR_DATE      = 8'h05;
    localparam logic [7:0] ADDR_WDAY      = 8'h06;
    localparam logic [7:0] ADDR_MON       = 8'h07;
    localparam logic [7:0] ADDR_YEAR      = 8'h08;
    localparam logic [7:0] ADDR_ALM_MIN   = 8'h09;
    localparam logic [7:0] ADDR_ALM_HOUR  = 8'h0A;
    localparam logic [7:0] ADDR_ALM_DATE  = 8'h0B;
    localparam logic [7:0] ADDR_ALM_WDAY  = 8'h0C;
    localparam logic [7:0] ADDR_SQCTL     = 8'h0D;
    localparam logic [7:0] ADDR_LAST      = 8'h0F;

    // bit positions
    localparam int FLAG_BIT  = 3;
    localparam int IRQEN_BIT = 1;
    localparam int STOP_BIT  = 7;
    localparam int OFF_BIT   = 7;
    localparam int SQEN_BIT  = 7;

    // implemented bits of each register
    localparam logic [7:0] MASK_SEC  = 8'h7F;
    localparam logic [7:0] MASK_MIN  = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_MON  = 8'h1F;
    localparam logic [7:0] MASK_AHR  = 8'hBF;
    localparam logic [7:0] MASK_ADT  = 8'hBF;
    localparam logic [7:0] MASK_AWD  = 8'h87;

    // values after reset
    localparam logic       RST_STOP  = 1'b1;
    localparam logic       RST_SQEN  = 1'b1;
    localparam logic       RST_IRQEN = 1'b0;
    localparam logic       RST_FLAG  = 1'b0;
    localparam logic [1:0] RST_RS   = 2'h0;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MON  = 8'h01;

    // counter limits in BCD
    localparam logic [7:0] SEC_LAST  = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] WDAY_LAST = 8'h06;
    localparam logic [7:0] MON_LAST  = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] DAY_FIRST = 8'h01;

    // crystal divider: wrap value and square-wave taps
    localparam logic [14:0] DIV_LAST = 15'h7FFF;
    localparam int TAP_1K  = 4;
    localparam int TAP_32  = 9;
    localparam int TAP_1   = 14;
    localparam logic [1:0] FSEL_32K = 2'h0;
    localparam logic [1:0] FSEL_1K  = 2'h1;
    localparam logic [1:0] FSEL_32  = 2'h2;
    localparam logic [1:0] FSEL_1   = 2'h3;

    // oscillator-stop watchdog, least time rounded up to cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_STOP_NS   = 100000;
    localparam logic [11:0] OSC_STOP_CYC =
        12'((OSC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // two-wire slave states, gray along idle-rx-ack-tx-txack
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'h0,
        BUS_RX    = 3'h1,
        BUS_ACK   = 3'h3,
        BUS_TX    = 3'h2,
        BUS_TXACK = 3'h6
    } bus_state_t;

endpackage

/* File: sim/rtc_asserts.sv */
// pin-level checks of the calendar core
// assumes scl phases of at least four ref_clk cycles
module rtc_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic crystal_in,
    input wire logic square_wave_output,
    input wire logic square_wave_oe,
    input wire logic alarm_int_out,
    input wire logic alarm_int_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic       xtal_q = 1'b0;
    logic [3:0] xcnt_q = 4'h0;
    // cycles since the crystal pin moved
    always_ff @(posedge ref_clk) begin
        xtal_q <= crystal_in;
        if (crystal_in != xtal_q) xcnt_q <= 4'h0;
        else if (xcnt_q != 4'hF) xcnt_q <= xcnt_q + 4'h1;
    end
    a_sq_rst: assert property (disable iff (1'b0) sys_rst |=>
        square_wave_oe && !square_wave_output) else $error("sq reset");
    a_pins_rst: assert property (disable iff (1'b0) sys_rst |=>
        !alarm_int_oe && !sda_oe) else $error("pins busy in reset");
    a_int_low: assert property (!alarm_int_out)
        else $error("int driven high");
    a_sda_low: assert property (!sda_out)
        else $error("data driven high");
    a_sda_move: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved in clock high");
    a_bit_hold: assert property ($rose(sda_oe) |-> sda_oe[*4])
        else $error("data pull too short");
    a_flag_hold: assert property ($fell(alarm_int_oe) |-> !scl_in)
        else $error("int dropped without write");
    a_sq_edge: assert property ($changed(square_wave_output) |->
        xcnt_q <= 4'h5) else $error("square wave off crystal");
    c_alarm: cover property ($rose(alarm_int_oe));
    c_sq_off: cover property ($fell(square_wave_oe));
    c_ack: cover property ($rose(sda_oe));
endmodule

bind bcd_calendar_alarm_sqw rtc_asserts u_chk (.ref_clk, .sys_rst,
    .scl_in, .sda_in, .sda_out, .sda_oe, .crystal_in, .square_wave_output,
    .square_wave_oe, .alarm_int_out, .alarm_int_oe);

/* File: sim/host_master.sv */
// bus master model standing in for the host processor
// assumes the data line is resolved outside with a pull-up
module host_master (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl_q = 1'b1,
    output logic      sda_pull = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // move just after a clock edge
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // start or repeated start: data falls while clock high
    task automatic st();
        tk(1);
        sda_pull = 1'b0;
        tk(2);
        scl_q = 1'b1;
        tk(4);
        sda_pull = 1'b1;
        tk(4);
        scl_q = 1'b0;
        tk(2);
    endtask
    // nine bits msb first, data moves only with clock low
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = ~d[i];
            tk(2);
            scl_q = 1'b1;
            tk(4);
            q[i] = sda_line;
            scl_q = 1'b0;
            tk(2);
        end
    endtask
    // stop, then both lines left released high
    task automatic sp();
        sda_pull = 1'b1;
        tk(2);
        scl_q = 1'b1;
        tk(4);
        sda_pull = 1'b0;
        tk(4);
    endtask
    // one-byte write, ok when all bytes acknowledged
    task automatic wr(input logic [6:0] a, input logic [7:0] p,
                      input logic [7:0] d, output logic ok);
        logic [8:0] q1, q2, q3;
        st();
        xb({a, 2'b01}, q1);
        xb({p, 1'b1}, q2);
        xb({d, 1'b1}, q3);
        sp();
        ok = !(q1[0] | q2[0] | q3[0]);
    endtask
    // pointer write, repeated start, one byte read ended by no ack
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [8:0] q;
        st();
        xb({rtc_pkg::SLAVE_ADDR, 2'b01}, q);
        xb({p, 1'b1}, q);
        st();
        xb({rtc_pkg::SLAVE_ADDR, 2'b11}, q);
        xb(9'h1FF, q);
        sp();
        d = q[8:1];
    endtask
endmodule

/* File: sim/tb_bcd_calendar_alarm_sqw.sv */
// self-checking bench of the calendar core
// assumes package, checker and host model compiled first
module tb_bcd_calendar_alarm_sqw;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] p;
        logic       we;
        logic [7:0] w;
        logic [7:0] e;
    } row_t;
    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       xtal = 1'b0;
    logic       xrun = 1'b1;
    logic       scl, pull, sda_oe, sq, sq_oe, int_oe, ok;
    wire logic  sda_line;
    logic [7:0] r;
    time        t0;
    int         miscompares = 0;
    int         compares = 0;
    int         n;
    row_t rows[12] = '{'{8'h01, 1'b0, 8'h00, 8'h00},
        '{8'h02, 1'b0, 8'h00, 8'h80}, '{8'h03, 1'b0, 8'h00, 8'h00},
        '{8'h05, 1'b0, 8'h00, 8'h01}, '{8'h07, 1'b0, 8'h00, 8'h01},
        '{8'h08, 1'b0, 8'h00, 8'h00}, '{8'h0C, 1'b0, 8'h00, 8'h80},
        '{8'h0D, 1'b0, 8'h00, 8'h80}, '{8'h0E, 1'b0, 8'h00, 8'h00},
        '{8'h06, 1'b1, 8'h03, 8'h03}, '{8'h0D, 1'b1, 8'h83, 8'h83},
        '{8'h0D, 1'b1, 8'h03, 8'h03}};
    logic [7:0] pre[11] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12,
        8'h99, 8'h00, 8'h00, 8'h80, 8'h80};
    logic [7:0] post[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    assign sda_line = !(sda_oe || pull); // open drain, pulled up
    always #12.5 ref_clk = ~ref_clk;
    // crystal stand-in, one cycle per level, can be stopped
    always @(posedge ref_clk) if (xrun) xtal <= ~xtal;
    host_master host (.clk(ref_clk), .sda_line(sda_line), .scl_q(scl),
        .sda_pull(pull));
    bcd_calendar_alarm_sqw dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
        .crystal_in(xtal), .square_wave_output(sq), .square_wave_oe(sq_oe),
        .alarm_int_out(), .alarm_int_oe(int_oe));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e);
        host.rd(p, r);
        chk({8'h00, r}, {8'h00, e});
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.wr(rtc_pkg::SLAVE_ADDR, p, d, ok);
        chk({15'h0, ok}, 16'h1);
    endtask
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog: the tests take about 75000 cycles
    initial begin
        repeat (99000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) wr(rows[i].p, rows[i].w);
            rdc(rows[i].p, rows[i].e);
        end
        chk({15'h0, sq_oe}, 16'h0);
        $display("test registers done");
        for (int s = 0; s < 3; s++) begin
            wr(8'h0D, 8'h80 | 8'(s));
            chk({15'h0, sq_oe}, 16'h1);
            @(posedge sq);
            t0 = $time;
            @(posedge sq);
            chk(16'(($time - t0) / 25), 16'h2 << (5 * s));
        end
        $display("test square wave done");
        foreach (pre[i]) wr(8'h02 + 8'(i), pre[i]);
        wr(8'h01, 8'h02);
        n = 0;
        while (int_oe !== 1'b1 && n < 70000) begin
            @(posedge ref_clk);
            n++;
        end
        chk({15'h0, int_oe}, 16'h1);
        foreach (post[i]) rdc(8'h02 + 8'(i), post[i]);
        rdc(8'h01, 8'h0A);
        wr(8'h01, 8'h0A);
        rdc(8'h01, 8'h0A);
        wr(8'h01, 8'h02);
        rdc(8'h01, 8'h02);
        chk({15'h0, int_oe}, 16'h0);
        $display("test rollover and alarm done");
        host.wr(7'h50, 8'h01, 8'h00, ok);
        chk({15'h0, ok}, 16'h0);
        host.wr(rtc_pkg::SLAVE_ADDR, 8'h10, 8'h00, ok);
        chk({15'h0, ok}, 16'h0);
        xrun = 1'b0;
        repeat (4100) @(posedge ref_clk);
        xrun = 1'b1;
        host.rd(8'h02, r);
        chk({8'h00, r & 8'h80}, 16'h80);
        $display("test refusals and stop flag done");
        wrap_up();
    end
endmodule
